// [rsp_pkg.sv]
package rsp_pkg;
   // clock and oversampling
   localparam int CLK_HZ     = 25_000_000;
   localparam int OVERSAMPLE = 16;
   // bit rates selected by baud index 0..6
   localparam int BAUD_0 = 1200;
   localparam int BAUD_1 = 2400;
   localparam int BAUD_2 = 4800;
   localparam int BAUD_3 = 9600;
   localparam int BAUD_4 = 19200;
   localparam int BAUD_5 = 38400;
   localparam int BAUD_6 = 14400;
   // end-of-message idle gap: 3.5 characters of 11 bits, in half bits
   localparam int GAP_HALF_BITS = 77;
   localparam int GAP_TICKS     = GAP_HALF_BITS * OVERSAMPLE / 2;
   // register byte offsets
   localparam logic [4:0] OFS_SETTING = 5'h00;
   localparam logic [4:0] OFS_ACTIVE  = 5'h04;
   localparam logic [4:0] OFS_STATUS  = 5'h08;
   localparam logic [4:0] OFS_MASK    = 5'h0C;
   localparam logic [4:0] OFS_TXDATA  = 5'h10;
   localparam logic [4:0] OFS_RXDATA  = 5'h14;
   localparam logic [4:0] OFS_STATE   = 5'h18;
   // setting field positions
   localparam int F_PROTO  = 0;
   localparam int F_STN_LO = 8;
   localparam int F_STN_HI = 13;
   localparam int F_BD_LO  = 16;
   localparam int F_BD_HI  = 18;
   localparam int F_STOP   = 20;
   localparam int F_PAR_LO = 24;
   localparam int F_PAR_HI = 25;
   // encodings
   localparam logic       PROTO_STD    = 1'h0;
   localparam logic       PROTO_MODBUS = 1'h1;
   localparam logic       STOP_TWO     = 1'h0;
   localparam logic [1:0] PAR_ODD      = 2'h0;
   localparam logic [1:0] PAR_NONE     = 2'h1;
   localparam logic [1:0] PAR_EVEN     = 2'h2;
   localparam logic [2:0] BAUD_IDX_MAX = 3'h6;
   localparam logic [5:0] STN_MIN      = 6'h01;
   localparam logic [5:0] STN_MAX      = 6'h20;
   // reset values: standard protocol, station 1, index 3, two stop, odd
   localparam logic [31:0] SETTING_RST = 32'h0003_0100;
   localparam logic [7:0]  STATUS_RST  = 8'h00;
   // status bits
   localparam int ST_RX_BYTE = 0;
   localparam int ST_MSG_END = 1;
   localparam int ST_SUM_ERR = 2;
   localparam int ST_PAR_ERR = 3;
   localparam int ST_FRM_ERR = 4;
   localparam int ST_TX_DONE = 5;
   localparam int ST_OVERRUN = 6;
   localparam int ST_W       = 8;
   // message checks
   localparam logic [7:0]  ASCII_ZERO = 8'h30;
   localparam logic [7:0]  DEC_TEN    = 8'h0A;
   localparam logic [15:0] CRC_INIT   = 16'hFFFF;
   localparam logic [15:0] CRC_POLY   = 16'hA001;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } rsp_rx_state_e;

   function automatic logic [11:0] rsp_baud_div(input logic [2:0] idx);
      int b;
      case (idx)
         3'h0: b = BAUD_0;
         3'h1: b = BAUD_1;
         3'h2: b = BAUD_2;
         3'h3: b = BAUD_3;
         3'h4: b = BAUD_4;
         3'h5: b = BAUD_5;
         default: b = BAUD_6;
      endcase
      return 12'((CLK_HZ + b * OVERSAMPLE / 2) / (b * OVERSAMPLE));
   endfunction : rsp_baud_div

   function automatic logic [15:0] rsp_crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : rsp_crc_byte
endpackage : rsp_pkg

// [rsp_rx.sv]
`timescale 1ns/1ns
module rsp_rx (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // oversampled line
   input  wire logic       tick,
   input  wire logic       rxd,
   input  wire logic       enable,
   input  wire logic [1:0] parity,
   // received character
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   output logic            par_err,
   output logic            frm_err,
   output logic            busy
);
   rsp_pkg::rsp_rx_state_e state_r;
   logic [3:0] phase_r;
   logic [2:0] bit_r;
   logic [7:0] sh_r;
   logic       par_bad_r;

   assign busy = (state_r != rsp_pkg::RX_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= rsp_pkg::RX_IDLE;
         phase_r    <= 4'h0;
         bit_r      <= 3'h0;
         sh_r       <= 8'h00;
         par_bad_r  <= 1'b0;
         byte_valid <= 1'b0;
         byte_data  <= 8'h00;
         par_err    <= 1'b0;
         frm_err    <= 1'b0;
      end else begin
         byte_valid <= 1'b0;
         if (!enable) begin
            state_r <= rsp_pkg::RX_IDLE;
         end else if (tick) begin
            phase_r <= phase_r + 4'h1;
            case (state_r)
               rsp_pkg::RX_IDLE: begin
                  phase_r <= 4'h0;
                  // a low sample while idle starts bit timing; later edges do not restart it
                  if (!rxd) state_r <= rsp_pkg::RX_START;
               end
               rsp_pkg::RX_START: begin
                  if (phase_r == 4'h7) begin
                     phase_r   <= 4'h0;
                     bit_r     <= 3'h0;
                     par_bad_r <= 1'b0;
                     state_r   <= rxd ? rsp_pkg::RX_IDLE : rsp_pkg::RX_DATA;
                  end
               end
               rsp_pkg::RX_DATA: begin
                  if (phase_r == 4'hF) begin
                     sh_r  <= {rxd, sh_r[7:1]};
                     bit_r <= bit_r + 3'h1;
                     if (bit_r == 3'h7) begin
                        state_r <= (parity == rsp_pkg::PAR_NONE) ? rsp_pkg::RX_STOP : rsp_pkg::RX_PAR;
                     end
                  end
               end
               rsp_pkg::RX_PAR: begin
                  if (phase_r == 4'hF) begin
                     par_bad_r <= (rxd ^ (^sh_r)) != (parity == rsp_pkg::PAR_ODD);
                     state_r   <= rsp_pkg::RX_STOP;
                  end
               end
               rsp_pkg::RX_STOP: begin
                  if (phase_r == 4'hF) begin
                     byte_valid <= 1'b1;
                     byte_data  <= sh_r;
                     par_err    <= par_bad_r;
                     frm_err    <= !rxd;
                     state_r    <= rsp_pkg::RX_IDLE;
                  end
               end
               default: state_r <= rsp_pkg::RX_IDLE;
            endcase
         end
      end
   end
endmodule : rsp_rx

// [rsp_tx.sv]
`timescale 1ns/1ns
module rsp_tx (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // character request
   input  wire logic       tick,
   input  wire logic       start,
   input  wire logic [7:0] data,
   input  wire logic [1:0] parity,
   input  wire logic       two_stop,
   // line side
   output logic            txd,
   output logic            busy,
   output logic            done
);
   logic [11:0] sh_r;
   logic [3:0]  phase_r;
   logic [3:0]  left_r;
   logic        pbit;

   assign txd  = sh_r[0];
   assign pbit = (^data) ^ (parity == rsp_pkg::PAR_ODD);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_r    <= 12'hFFF;
         phase_r <= 4'h0;
         left_r  <= 4'h0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            // start, eight data bits, optional parity, stop bits
            sh_r    <= {2'b11, (parity == rsp_pkg::PAR_NONE) ? 1'b1 : pbit, data, 1'b0};
            left_r  <= 4'd10 + ((parity == rsp_pkg::PAR_NONE) ? 4'd0 : 4'd1)
                       + (two_stop ? 4'd1 : 4'd0);
            phase_r <= 4'h0;
            busy    <= 1'b1;
         end else if (busy && tick) begin
            phase_r <= phase_r + 4'h1;
            if (phase_r == 4'hF) begin
               sh_r   <= {1'b1, sh_r[11:1]};
               left_r <= left_r - 4'h1;
               if (left_r == 4'h1) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
         end
      end
   end
endmodule : rsp_tx

// [rsp_serial_slave.sv]
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
// Contract
// - seven selectable bit rates, both ends equal
// - one start bit, eight data bits
// - one or two stop bits
// - parity none, odd or even, checked
// - half duplex, never send while receiving
// - report sum, parity and framing errors
// - binary bytes or ASCII, per protocol
// - Modbus-RTU or standard protocol, one active
// - answer only own station 1 to 32
// - reset defaults standard, 9600, two, odd, 01
// - baud index 5 means 38400
// - settings apply only after power cycle
module rsp_serial_slave (
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   // avalon-mm slave
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // rs485 line driver
   input  wire logic        RS485_RXD,
   output logic             RS485_TXD,
   output logic             RS485_DE,
   // control power good
   input  wire logic        CTRL_PWR_OK,
   // interrupt
   output logic             IRQ
);
   localparam int ST_W_M = rsp_pkg::ST_W - 1;
   localparam logic [9:0] GAP_LAST = 10'(rsp_pkg::GAP_TICKS - 1);

   logic [2:0]  rxd_sync_r;
   logic        rxd_f_r;
   logic [2:0]  pwr_sync_r;
   logic        pwr_f_r;
   logic        pwr_d_r;
   logic        pwr_rise;
   logic        ack_r;
   logic        acc_wr;
   logic        acc_rd;
   logic [31:0] wmask;
   logic [31:0] set_r;
   logic [31:0] set_nxt;
   logic        set_ok;
   logic [31:0] act_r;
   logic        act_proto;
   logic [5:0]  act_stn;
   logic [2:0]  act_baud;
   logic        act_stop;
   logic [1:0]  act_par;
   logic [11:0] div_r;
   logic        tick_r;
   logic [ST_W_M:0] st_r;
   logic [ST_W_M:0] st_set;
   logic [ST_W_M:0] st_clr;
   logic [ST_W_M:0] mask_r;
   logic [7:0]  hold_r;
   logic        hold_v_r;
   logic [7:0]  rxdata_r;
   logic [31:0] rd_nxt;
   logic        rxv;
   logic [7:0]  rxb;
   logic        rx_perr;
   logic        rx_ferr;
   logic        rx_busy;
   logic        tx_busy;
   logic        tx_start;
   logic        de_r;
   logic        de_end;
   logic [9:0]  gap_r;
   logic        gap_end;
   logic        in_msg_r;
   logic [1:0]  idx_r;
   logic [7:0]  tens_r;
   logic        addr_ok_r;
   logic        err_seen_r;
   logic [7:0]  sum_r;
   logic [7:0]  prev_sum_r;
   logic [7:0]  last_r;
   logic [15:0] crc_r;
   logic        sum_bad;
   logic        msg_end;
   logic        reply_ok_r;
   logic [7:0]  digit;

   // line and power inputs: three stages, accept when last two agree
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rxd_sync_r <= 3'h7;
         rxd_f_r    <= 1'b1;
      end else begin
         rxd_sync_r <= {rxd_sync_r[1:0], RS485_RXD};
         if (rxd_sync_r[2] == rxd_sync_r[1]) rxd_f_r <= rxd_sync_r[2];
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         // idle at power good, so leaving reset is no false rise
         pwr_sync_r <= 3'h7;
         pwr_f_r    <= 1'b1;
         pwr_d_r    <= 1'b1;
      end else begin
         pwr_sync_r <= {pwr_sync_r[1:0], CTRL_PWR_OK};
         if (pwr_sync_r[2] == pwr_sync_r[1]) pwr_f_r <= pwr_sync_r[2];
         pwr_d_r <= pwr_f_r;
      end
   end

   assign pwr_rise = pwr_f_r && !pwr_d_r;

   // bus handshake: one wait state for every access
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
   assign acc_wr          = AVS_WRITE && ack_r;
   assign acc_rd          = AVS_READ && !ack_r;
   assign wmask           = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                             {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) ack_r <= 1'b0;
      else ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
   end

   // pending settings: only legal combinations are stored
   assign set_nxt = (set_r & ~wmask) | (AVS_WRITEDATA & wmask);
   assign set_ok  = (set_nxt[rsp_pkg::F_STN_HI:rsp_pkg::F_STN_LO] >= rsp_pkg::STN_MIN)
                 && (set_nxt[rsp_pkg::F_STN_HI:rsp_pkg::F_STN_LO] <= rsp_pkg::STN_MAX)
                 && (set_nxt[rsp_pkg::F_BD_HI:rsp_pkg::F_BD_LO] <= rsp_pkg::BAUD_IDX_MAX)
                 && (set_nxt[rsp_pkg::F_PAR_HI:rsp_pkg::F_PAR_LO] != 2'h3);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) set_r <= rsp_pkg::SETTING_RST;
      else if (acc_wr && AVS_ADDRESS == rsp_pkg::OFS_SETTING && set_ok) set_r <= set_nxt;
   end

   // running settings follow pending ones only on control power up
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) act_r <= rsp_pkg::SETTING_RST;
      else if (pwr_rise) act_r <= set_r;
   end

   assign act_proto = act_r[rsp_pkg::F_PROTO];
   assign act_stn   = act_r[rsp_pkg::F_STN_HI:rsp_pkg::F_STN_LO];
   assign act_baud  = act_r[rsp_pkg::F_BD_HI:rsp_pkg::F_BD_LO];
   assign act_stop  = act_r[rsp_pkg::F_STOP];
   assign act_par   = act_r[rsp_pkg::F_PAR_HI:rsp_pkg::F_PAR_LO];

   // oversampling tick at sixteen times the bit rate
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_r  <= 12'h000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= 1'b0;
         if (div_r >= rsp_pkg::rsp_baud_div(act_baud) - 12'h001) begin
            div_r  <= 12'h000;
            tick_r <= 1'b1;
         end else begin
            div_r <= div_r + 12'h001;
         end
      end
   end

   // receiver is blind while our own driver is on
   rsp_rx u_rx (
      .clk        (REF_CLK),
      .rst_n      (RST_N),
      .tick       (tick_r),
      .rxd        (rxd_f_r),
      .enable     (!de_r),
      .parity     (act_par),
      .byte_valid (rxv),
      .byte_data  (rxb),
      .par_err    (rx_perr),
      .frm_err    (rx_ferr),
      .busy       (rx_busy)
   );

   rsp_tx u_tx (
      .clk      (REF_CLK),
      .rst_n    (RST_N),
      .tick     (tick_r),
      .start    (tx_start),
      .data     (hold_r),
      .parity   (act_par),
      .two_stop (act_stop == rsp_pkg::STOP_TWO),
      .txd      (RS485_TXD),
      .busy     (tx_busy),
      .done     ()
   );

   // idle gap after the last character closes a message
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) gap_r <= 10'h000;
      else if (rx_busy || rxv) gap_r <= 10'h000;
      else if (tick_r && gap_r != GAP_LAST) gap_r <= gap_r + 10'h001;
   end

   assign gap_end = tick_r && !rx_busy && (gap_r == GAP_LAST - 10'h001);
   assign digit   = rxb - rsp_pkg::ASCII_ZERO;

   // message framing, station match and running checks
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         in_msg_r   <= 1'b0;
         idx_r      <= 2'h0;
         tens_r     <= 8'h00;
         addr_ok_r  <= 1'b0;
         err_seen_r <= 1'b0;
         sum_r      <= 8'h00;
         prev_sum_r <= 8'h00;
         last_r     <= 8'h00;
         crc_r      <= rsp_pkg::CRC_INIT;
      end else if (rxv) begin
         in_msg_r <= 1'b1;
         last_r   <= rxb;
         if (!in_msg_r) begin
            idx_r      <= 2'h1;
            err_seen_r <= rx_perr || rx_ferr;
            sum_r      <= rxb;
            prev_sum_r <= 8'h00;
            crc_r      <= rsp_pkg::rsp_crc_byte(rsp_pkg::CRC_INIT, rxb);
            tens_r     <= digit;
            // binary station byte vs two ascii digits
            addr_ok_r  <= (act_proto == rsp_pkg::PROTO_MODBUS) && (rxb == {2'b00, act_stn});
         end else begin
            if (idx_r != 2'h2) idx_r <= idx_r + 2'h1;
            err_seen_r <= err_seen_r || rx_perr || rx_ferr;
            sum_r      <= sum_r + rxb;
            prev_sum_r <= sum_r;
            crc_r      <= rsp_pkg::rsp_crc_byte(crc_r, rxb);
            if (idx_r == 2'h1 && act_proto == rsp_pkg::PROTO_STD) begin
               addr_ok_r <= (8'(tens_r * rsp_pkg::DEC_TEN) + digit) == {2'b00, act_stn};
            end
         end
      end else if (gap_end) begin
         in_msg_r <= 1'b0;
      end
   end

   // modbus checks crc16 residue, standard checks byte sum
   assign sum_bad = (act_proto == rsp_pkg::PROTO_MODBUS) ? (crc_r != 16'h0000)
                                                         : (prev_sum_r != last_r);
   assign msg_end = gap_end && in_msg_r && addr_ok_r;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) reply_ok_r <= 1'b0;
      else if (msg_end) reply_ok_r <= !sum_bad && !err_seen_r;
      else if (rxv || de_end) reply_ok_r <= 1'b0;
   end

   // transmit holding byte and driver enable
   assign tx_start = hold_v_r && !tx_busy && reply_ok_r && !rx_busy && !in_msg_r;
   assign de_end   = de_r && !tx_busy && !hold_v_r && !tx_start;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         hold_r   <= 8'h00;
         hold_v_r <= 1'b0;
      end else if (tx_start) begin
         hold_v_r <= 1'b0;
      end else if (acc_wr && AVS_ADDRESS == rsp_pkg::OFS_TXDATA && AVS_BYTEENABLE[0]
                   && !hold_v_r && reply_ok_r) begin
         hold_r   <= AVS_WRITEDATA[7:0];
         hold_v_r <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) de_r <= 1'b0;
      else if (tx_start) de_r <= 1'b1;
      else if (de_end) de_r <= 1'b0;
   end

   assign RS485_DE = de_r;

   // received character register
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) rxdata_r <= 8'h00;
      else if (rxv) rxdata_r <= rxb;
   end

   // sticky status, write one to clear, a new event wins
   always_comb begin
      st_set = '0;
      st_set[rsp_pkg::ST_RX_BYTE] = rxv;
      st_set[rsp_pkg::ST_MSG_END] = msg_end;
      st_set[rsp_pkg::ST_SUM_ERR] = msg_end && sum_bad;
      st_set[rsp_pkg::ST_PAR_ERR] = rxv && rx_perr;
      st_set[rsp_pkg::ST_FRM_ERR] = rxv && rx_ferr;
      st_set[rsp_pkg::ST_TX_DONE] = de_end;
      st_set[rsp_pkg::ST_OVERRUN] = rxv && st_r[rsp_pkg::ST_RX_BYTE];
   end

   assign st_clr = (acc_wr && AVS_ADDRESS == rsp_pkg::OFS_STATUS)
                 ? (AVS_WRITEDATA[ST_W_M:0] & wmask[ST_W_M:0]) : '0;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) st_r <= rsp_pkg::STATUS_RST;
      else st_r <= (st_r & ~st_clr) | st_set;
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) mask_r <= rsp_pkg::STATUS_RST;
      else if (acc_wr && AVS_ADDRESS == rsp_pkg::OFS_MASK) begin
         mask_r <= (mask_r & ~wmask[ST_W_M:0]) | (AVS_WRITEDATA[ST_W_M:0] & wmask[ST_W_M:0]);
      end
   end

   assign IRQ = |(st_r & mask_r);

   // read data is captured in the wait state
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (AVS_ADDRESS == rsp_pkg::OFS_SETTING) begin
         rd_nxt = set_r;
      end else if (AVS_ADDRESS == rsp_pkg::OFS_ACTIVE) begin
         rd_nxt = act_r;
      end else if (AVS_ADDRESS == rsp_pkg::OFS_STATUS) begin
         rd_nxt[ST_W_M:0] = st_r;
      end else if (AVS_ADDRESS == rsp_pkg::OFS_MASK) begin
         rd_nxt[ST_W_M:0] = mask_r;
      end else if (AVS_ADDRESS == rsp_pkg::OFS_TXDATA) begin
         rd_nxt[7:0] = hold_r;
      end else if (AVS_ADDRESS == rsp_pkg::OFS_RXDATA) begin
         rd_nxt[7:0] = rxdata_r;
      end else if (AVS_ADDRESS == rsp_pkg::OFS_STATE) begin
         rd_nxt[6:0] = {addr_ok_r, reply_ok_r, in_msg_r, rx_busy, de_r, tx_busy, hold_v_r};
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) AVS_READDATA <= 32'h0000_0000;
      else if (acc_rd) AVS_READDATA <= rd_nxt;
   end
endmodule : rsp_serial_slave

// [rsp_chk.sv]
`timescale 1ns/1ns
module rsp_chk (
   // clock and reset
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   // register bus
   input wire logic [4:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   // line and interrupt
   input wire logic        RS485_TXD,
   input wire logic        RS485_DE,
   input wire logic        IRQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   wire req = AVS_READ | AVS_WRITE;

   property p_wait_first; req && !$past(req) |-> AVS_WAITREQUEST; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
   property p_wait_one; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait too long");
   property p_wait_idle; !req |-> !AVS_WAITREQUEST; endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("wait while idle");
   property p_unmapped;
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > rsp_pkg::OFS_STATE |-> AVS_READDATA == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_line_idle; !RS485_DE |-> RS485_TXD; endproperty
   a_line_idle: assert property (p_line_idle) else $error("txd low while released");
   property p_de_start; $rose(RS485_DE) |-> !RS485_TXD; endproperty
   a_de_start: assert property (p_de_start) else $error("reply not opened by start");
   property p_de_end; $fell(RS485_DE) |-> $past(RS485_TXD, 8); endproperty
   a_de_end: assert property (p_de_end) else $error("driver dropped inside a bit");
   property p_bit_len; $changed(RS485_TXD) |=> $stable(RS485_TXD)[*8]; endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit too short");
   property p_reset_out; $rose(RST_N) |-> RS485_TXD && !RS485_DE && !IRQ; endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not idle at reset");
endmodule : rsp_chk

bind rsp_serial_slave rsp_chk u_chk (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .RS485_TXD(RS485_TXD), .RS485_DE(RS485_DE), .IRQ(IRQ)
);

// [rsp_host.sv]
`timescale 1ns/1ns
module rsp_host (
   // clock
   input wire logic clk,
   // shared pair
   output logic      line_rx,
   input wire logic  line_tx,
   input wire logic  line_de
);
   // 25 MHz / 38400
   localparam int BIT_CLKS = 651;
   logic drv_r;
   initial drv_r = 1'b1;
   // the pair shows the slave while it drives, else the host or idle bias
   assign line_rx = line_de ? line_tx : drv_r;

   task automatic put_bit(input logic b);
      drv_r <= b;
      repeat (BIT_CLKS) @(posedge clk);
   endtask : put_bit

   // even parity, one stop; bad corrupts parity and stop
   task automatic send(input logic [7:0] d, input logic bad);
      while (line_de) @(posedge clk);
      put_bit(1'b0);
      for (int i = 0; i < 8; i++) put_bit(d[i]);
      put_bit(^d ^ bad);
      put_bit(~bad);
      // idle bit restores the line after a cut stop
      put_bit(1'b1);
   endtask : send

   task automatic recv(output logic [7:0] d, output logic p);
      while (line_rx) @(posedge clk);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         d[i] = line_rx;
      end
      repeat (BIT_CLKS) @(posedge clk);
      p = line_rx;
   endtask : recv
endmodule : rsp_host

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
   localparam logic [31:0] NEW_SET = 32'h0215_0100;
   logic        ref_clk;
   logic        rst_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        rxd;
   logic        txd;
   logic        de;
   logic        pwr_ok;
   logic        irq;
   logic [31:0] rd;
   logic [7:0]  rb;
   logic        rp;
   int          error_cnt;
   int          num_checks;
   int          cyc;

   rsp_serial_slave u_rsp_serial_slave (
      .REF_CLK(ref_clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .RS485_RXD(rxd),
      .RS485_TXD(txd), .RS485_DE(de), .CTRL_PWR_OK(pwr_ok), .IRQ(irq));
   rsp_host u_rsp_host (.clk(ref_clk), .line_rx(rxd), .line_tx(txd), .line_de(de));

   task automatic avs_xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= wd;
      @(posedge ref_clk);
      while (avs_waitrequest) @(posedge ref_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : avs_xfer

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      avs_xfer(1'b0, a, 32'h0000_0000);
      chk(n, e, rd & m);
   endtask : rdchk

   task automatic report_and_stop;
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 100000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      pwr_ok = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      cyc = 0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk(rsp_pkg::OFS_SETTING, 32'hFFFF_FFFF, rsp_pkg::SETTING_RST, "setting");
      rdchk(rsp_pkg::OFS_ACTIVE, 32'hFFFF_FFFF, rsp_pkg::SETTING_RST, "active");
      rdchk(5'h1C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
      avs_xfer(1'b1, rsp_pkg::OFS_SETTING, 32'h0215_0000);
      rdchk(rsp_pkg::OFS_SETTING, 32'hFFFF_FFFF, rsp_pkg::SETTING_RST, "station 0");
      avs_xfer(1'b1, rsp_pkg::OFS_SETTING, NEW_SET);
      rdchk(rsp_pkg::OFS_ACTIVE, 32'hFFFF_FFFF, rsp_pkg::SETTING_RST, "early apply");
      pwr_ok <= 1'b0;
      repeat (8) @(posedge ref_clk);
      pwr_ok <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rdchk(rsp_pkg::OFS_ACTIVE, 32'hFFFF_FFFF, NEW_SET, "applied");
      // station "01" in ascii, then the byte sum
      u_rsp_host.send(8'h30, 1'b0);
      u_rsp_host.send(8'h31, 1'b0);
      u_rsp_host.send(8'h61, 1'b0);
      rd = 32'h0000_0000;
      for (int i = 0; i < 300 && rd[rsp_pkg::ST_MSG_END] !== 1'b1; i++) begin
         repeat (100) @(posedge ref_clk);
         avs_xfer(1'b0, rsp_pkg::OFS_STATUS, 32'h0000_0000);
      end
      chk("status", 32'h0000_0043, rd);
      rdchk(rsp_pkg::OFS_RXDATA, 32'h0000_00FF, 32'h0000_0061, "rxdata");
      rdchk(rsp_pkg::OFS_STATE, 32'h0000_0060, 32'h0000_0060, "reply allowed");
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      avs_xfer(1'b1, rsp_pkg::OFS_MASK, 32'h0000_0002);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      avs_xfer(1'b1, rsp_pkg::OFS_STATUS, 32'h0000_0043);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      avs_xfer(1'b1, rsp_pkg::OFS_TXDATA, 32'h0000_00A5);
      u_rsp_host.recv(rb, rp);
      chk("reply byte", 32'h0000_00A5, {24'h0, rb});
      chk("reply parity", 32'h0000_0000, {31'h0, ^{rb, rp}});
      for (int i = 0; i < 2000 && de !== 1'b0; i++) @(posedge ref_clk);
      rdchk(rsp_pkg::OFS_STATUS, 32'h0000_0021, 32'h0000_0020, "reply done");
      u_rsp_host.send(8'h55, 1'b1);
      repeat (100) @(posedge ref_clk);
      rdchk(rsp_pkg::OFS_STATUS, 32'h0000_0018, 32'h0000_0018, "parity framing");
      report_and_stop();
   end
endmodule : testbench
